// File: inc/ctw_pkg.sv
// Constants, register map and state encodings for the CPU timing and wait-state controller
package ctw_pkg;
   // Register port geometry
   localparam int ADDR_W = 2;
   localparam int DATA_W = 8;
   // Register indices on the plain register port
   localparam logic [1:0] DEV_CTRL_ADDR = 2'h0;
   localparam logic [1:0] AUX_CTRL_ADDR = 2'h1;
   localparam logic [1:0] REM_CFG_ADDR = 2'h2;
   localparam logic [1:0] STATUS_ADDR = 2'h3;
   // Field positions
   localparam int IW_HI = 4;
   localparam int IW_LO = 3;
   localparam int DW_HI = 2;
   localparam int DW_LO = 0;
   localparam int FOUR_READ_BIT = 0;
   localparam int RUN_BIT = 0;
   // Widths of the wait counters
   localparam int IW_W = 2;
   localparam int DW_W = 3;
   // Reset values
   localparam logic [IW_W-1:0] IW_RESET = 2'h3;
   localparam logic [DW_W-1:0] DW_RESET = 3'h7;
   localparam logic FOUR_READ_RESET = 1'b0;
   localparam logic RUN_RESET = 1'b0;
   // Extra TX states after the first one
   localparam logic [1:0] TX_NONE = 2'h0;
   localparam logic [1:0] TX_ONE_MORE = 2'h1;
   // Pin synchroniser depth
   localparam int SYNC_STAGES = 3;
   // Number of synchronised pins: wait and lock
   localparam int SYNC_PINS = 2;

   // Instruction timing class, given by the decoder
   typedef enum logic [2:0] {
      CLS_2T = 3'h0,
      CLS_3T_PROG = 3'h1,
      CLS_DATA = 3'h2,
      CLS_4T_PROG = 3'h3,
      CLS_4T_TWO_WORD = 3'h4
   } ctw_class_type;

   // Timing-control states, one-hot
   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_FIRST_FETCH = 6'h02,
      ST_T1 = 6'h04,
      ST_TX = 6'h08,
      ST_TW = 6'h10,
      ST_T2 = 6'h20
   } ctw_state_type;
endpackage

// File: src/ctw_timing_ctrl.sv
// CPU timing controller: T-state sequencing, wait states, start/stop and bus strobes
//
// Contract
// - Reset gives three instruction, seven data waits.
// - Control bits 4:3 instruction, 2:0 data waits.
// - Instruction wait change delayed unless program control.
// - Data wait change applies at next access.
// - Four-state read change applies at next access.
// - Wait states are TW before final T2.
// - Data access waits: max(data, instruction minus one).
// - Four-state read absorbs one data wait.
// - Two-word instruction waits applied per word.
// - Low wait input keeps adding TW states.
// - Wait input sampled alongside programmed waits.
// - Halted and idle after reset until started.
// - Run bit starts at current address, clear stops.
// - Cleared run bit stops after the instruction's last T2.
// - Strap pins at reset release cause kick-start.
// - Kick-start enters first fetch next edge.
// - State changes only on rising clock edges.
// - Start runs a dummy fetch cycle first.
// - Boundary clock falls entering T2, TW or data TX.
// - Data T1: boundary clock, address latch, request bus.
// - Data T1 holds while locked or remote busy.
// - Data TX loads data counter, decrements instruction.
// - Write strobe low from TW; T2 when counters done.
`timescale 1ns/1ps
module ctw_timing_ctrl
   import ctw_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic [ADDR_W-1:0] i_reg_addr,
   input wire logic [DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [DATA_W-1:0] o_reg_rdata,
   input wire logic [2:0] i_instr_class,
   input wire logic i_data_read,
   input wire logic i_wait_b,
   input wire logic i_lock_b,
   input wire logic i_remote_busy,
   input wire logic i_remote_write_strobe_b,
   input wire logic i_remote_read_strobe_b,
   input wire logic i_remote_access_enable,
   output logic o_instruction_boundary_clock,
   output logic o_addr_latch,
   output logic o_write_strobe_b,
   output logic o_read_strobe_b,
   output logic o_bus_req,
   output logic o_instr_start,
   output logic o_pc_clear,
   output logic o_cpu_halted
);

   // Saturating decrement, shared by both wait counters
   function automatic logic [DW_W-1:0] sat_dec(input logic [DW_W-1:0] v);
      sat_dec = (v == '0) ? v : v - 3'h1;
   endfunction

   // Software-visible registers
   logic [IW_W-1:0] iw_sel_reg; // Instruction wait count
   logic [DW_W-1:0] dw_sel_reg; // Data wait count
   logic four_state_read_select; // Extra read TX
   logic cpu_run_bit; // Start/stop
   logic [DATA_W-1:0] rdata_reg; // Read data, one cycle late

   // Sequencer state
   ctw_state_type state_reg;
   ctw_state_type state_next;
   ctw_class_type cls_reg; // Class of the running instruction
   ctw_class_type cls_next;
   logic rd_reg; // Running access is a read
   logic rd_next;
   logic [IW_W-1:0] iw_cnt_reg; // Instruction wait counter
   logic [IW_W-1:0] iw_cnt_next;
   logic [DW_W-1:0] dw_cnt_reg; // Data wait counter
   logic [DW_W-1:0] dw_cnt_next;
   logic [1:0] tx_left_reg; // TX states still to run
   logic [1:0] tx_left_next;
   logic first_tx_reg; // In the first TX of a data access
   logic first_tx_next;
   logic second_word_reg; // Second word of a two-word instruction
   logic second_word_next;
   logic [IW_W-1:0] iw_prev_reg; // Count latched at previous instruction start
   logic [IW_W-1:0] iw_word_reg; // Count used for this instruction's words
   logic [IW_W-1:0] iw_load; // Count loaded on entry to T1
   logic booted_reg; // First edge after reset already seen
   logic kick_start; // Strap pattern seen at reset release

   // Registered outputs
   logic instruction_boundary_clock_reg;
   logic ale_reg;
   logic wr_b_reg;
   logic rd_b_reg;
   logic start_reg;
   logic pc_clear_reg;

   // Pin synchronisers: bit 0 wait, bit 1 lock
   logic [SYNC_PINS-1:0] sync_s1_reg;
   logic [SYNC_PINS-1:0] sync_s2_reg;
   logic [SYNC_PINS-1:0] sync_s3_reg;
   logic [SYNC_PINS-1:0] pin_filt_reg; // Accepted pin levels
   logic [SYNC_PINS-1:0] pin_raw;

   // Decoded conditions
   logic wait_low; // External wait asserted
   logic lock_low; // Bus lock asserted
   logic is_data; // Running instruction is a data access
   logic instr_wait_pending;
   logic data_wait_pending;
   logic waits_done;
   logic at_boundary; // End of T2, point B
   logic wr_dev;
   logic wr_aux;
   logic wr_rem;
   logic new_is_prog;
   logic go_start;
   logic [DW_W-1:0] iw_dec_wide; // Instruction count minus one, widened for the shared function
   logic [IW_W-1:0] iw_dec; // Instruction count minus one, saturating
   logic [DW_W-1:0] dw_dec; // Data count minus one, saturating
   logic counting; // State in which the wait counters move
   logic [IW_W-1:0] iw_after; // Instruction count on leaving this state
   logic [DW_W-1:0] dw_after; // Data count on leaving this state

   // Register port decode
   assign wr_dev = i_reg_wr && (i_reg_addr == DEV_CTRL_ADDR);
   assign wr_aux = i_reg_wr && (i_reg_addr == AUX_CTRL_ADDR);
   assign wr_rem = i_reg_wr && (i_reg_addr == REM_CFG_ADDR);

   // Pin conditions after filtering
   assign pin_raw = {i_lock_b, i_wait_b};
   assign wait_low = ~pin_filt_reg[0];
   assign lock_low = ~pin_filt_reg[1];
   assign is_data = (cls_reg == CLS_DATA);
   assign instr_wait_pending = (iw_after != '0);
   assign data_wait_pending = (dw_after != '0);
   // Wait pin counts exactly like a programmed wait state
   assign waits_done = !instr_wait_pending && !data_wait_pending && !wait_low;
   assign at_boundary = (state_reg == ST_T2);
   assign new_is_prog = (i_instr_class == CLS_3T_PROG) || (i_instr_class == CLS_4T_PROG);
   // Kick-start pattern, only on the first edge after release
   assign kick_start = !booted_reg && !i_remote_write_strobe_b && !i_remote_read_strobe_b
                       && i_remote_access_enable;
   assign go_start = kick_start || cpu_run_bit;

   // Program control picks up a new count at once, others one instruction later
   assign iw_load = new_is_prog ? iw_sel_reg : iw_prev_reg;

   // Counter values after this state, kept outside the sequencer process so
   // the wait decision never loops back through it
   assign iw_dec_wide = sat_dec({1'b0, iw_cnt_reg});
   assign iw_dec = iw_dec_wide[IW_W-1:0];
   assign dw_dec = sat_dec(dw_cnt_reg);
   assign counting = (state_reg == ST_TW) || (state_reg == ST_TX && is_data);
   assign iw_after = counting ? iw_dec : iw_cnt_reg;
   // Data count read live so a write just before still applies
   assign dw_after = (state_reg == ST_TX && is_data && first_tx_reg) ? dw_sel_reg
                     : (counting ? dw_dec : dw_cnt_reg);

   // Three-stage synchroniser; a change counts once stages two and three agree
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sync_s1_reg <= '1;
         sync_s2_reg <= '1;
         sync_s3_reg <= '1;
         pin_filt_reg <= '1;
      end else begin
         sync_s1_reg <= pin_raw;
         sync_s2_reg <= sync_s1_reg;
         sync_s3_reg <= sync_s2_reg;
         pin_filt_reg <= (sync_s2_reg == sync_s3_reg) ? sync_s3_reg : pin_filt_reg;
      end
   end

   // Control registers; strap pins are taken on the clock after release, never in reset
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         iw_sel_reg <= IW_RESET;
         dw_sel_reg <= DW_RESET;
         four_state_read_select <= FOUR_READ_RESET;
         cpu_run_bit <= RUN_RESET;
         booted_reg <= 1'b0;
      end else begin
         booted_reg <= 1'b1;
         if (wr_dev) begin
            iw_sel_reg <= i_reg_wdata[IW_HI:IW_LO];
            dw_sel_reg <= i_reg_wdata[DW_HI:DW_LO];
         end
         if (wr_aux) begin
            four_state_read_select <= i_reg_wdata[FOUR_READ_BIT];
         end
         // Kick-start sets the run bit so execution carries on past the first instruction
         if (kick_start) begin
            cpu_run_bit <= 1'b1;
         end else if (wr_rem) begin
            cpu_run_bit <= i_reg_wdata[RUN_BIT];
         end
      end
   end

   // Read data stand in the cycle after the strobe; unmapped bits read zero
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         rdata_reg <= '0;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            DEV_CTRL_ADDR: rdata_reg <= {3'h0, iw_sel_reg, dw_sel_reg};
            AUX_CTRL_ADDR: rdata_reg <= {7'h00, four_state_read_select};
            REM_CFG_ADDR: rdata_reg <= {7'h00, cpu_run_bit};
            STATUS_ADDR: rdata_reg <= {2'h0, state_reg};
         endcase
      end else begin
         rdata_reg <= '0;
      end
   end

   // Next-state logic of the timing sequencer
   always_comb begin
      state_next = state_reg;
      cls_next = cls_reg;
      rd_next = rd_reg;
      iw_cnt_next = iw_cnt_reg;
      dw_cnt_next = dw_cnt_reg;
      tx_left_next = tx_left_reg;
      first_tx_next = 1'b0;
      second_word_next = second_word_reg;
      unique case (state_reg)
         ST_IDLE: begin
            // Held here from reset until started
            if (go_start) begin
               state_next = ST_FIRST_FETCH;
            end
         end
         ST_FIRST_FETCH: begin
            // Dummy cycle that only fetches the first instruction
            state_next = ST_T1;
            cls_next = CLS_2T;
            rd_next = 1'b0;
            second_word_next = 1'b1;
            iw_cnt_next = iw_sel_reg;
            dw_cnt_next = '0;
         end
         ST_T1: begin
            if (is_data) begin
               // Enter TX only with the bus free
               if (!lock_low && !i_remote_busy) begin
                  state_next = ST_TX;
                  first_tx_next = 1'b1;
                  tx_left_next = (rd_reg && four_state_read_select) ? TX_ONE_MORE : TX_NONE;
               end
            end else if (cls_reg == CLS_3T_PROG) begin
               state_next = ST_TX;
               tx_left_next = TX_NONE;
            end else if (cls_reg == CLS_4T_PROG) begin
               state_next = ST_TX;
               tx_left_next = TX_ONE_MORE;
            end else begin
               state_next = waits_done ? ST_T2 : ST_TW;
            end
         end
         ST_TX: begin
            if (is_data) begin
               // TX stands for one instruction wait state in a data access
               iw_cnt_next = iw_after;
               // Data count loaded at the first TX, counted down after
               dw_cnt_next = dw_after;
            end
            if (tx_left_reg != TX_NONE) begin
               // Second TX of a four-state read takes up one data wait
               tx_left_next = tx_left_reg - 2'h1;
            end else begin
               state_next = waits_done ? ST_T2 : ST_TW;
            end
         end
         ST_TW: begin
            // Both counters run at once
            iw_cnt_next = iw_after;
            dw_cnt_next = dw_after;
            state_next = waits_done ? ST_T2 : ST_TW;
         end
         ST_T2: begin
            // Point B: second word, next instruction or stop
            if (cls_reg == CLS_4T_TWO_WORD && !second_word_reg) begin
               state_next = ST_T1;
               second_word_next = 1'b1;
               iw_cnt_next = iw_word_reg;
            end else if (cpu_run_bit) begin
               state_next = ST_T1;
               cls_next = ctw_class_type'(i_instr_class);
               rd_next = i_data_read;
               second_word_next = 1'b0;
               iw_cnt_next = iw_load;
               dw_cnt_next = '0;
            end else begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers, all moving on the rising edge
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_reg <= ST_IDLE;
         cls_reg <= CLS_2T;
         rd_reg <= 1'b0;
         iw_cnt_reg <= '0;
         dw_cnt_reg <= '0;
         tx_left_reg <= TX_NONE;
         first_tx_reg <= 1'b0;
         second_word_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cls_reg <= cls_next;
         rd_reg <= rd_next;
         iw_cnt_reg <= iw_cnt_next;
         dw_cnt_reg <= dw_cnt_next;
         tx_left_reg <= tx_left_next;
         first_tx_reg <= first_tx_next;
         second_word_reg <= second_word_next;
      end
   end

   // Instruction wait counts latched at each instruction start
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         iw_prev_reg <= IW_RESET;
         iw_word_reg <= IW_RESET;
      end else if (at_boundary && cpu_run_bit && state_next == ST_T1 && !second_word_next) begin
         iw_prev_reg <= iw_sel_reg;
         iw_word_reg <= iw_load;
      end
   end

   // Strobes and pulses registered from the next state so they change with it
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         instruction_boundary_clock_reg <= 1'b0;
         ale_reg <= 1'b0;
         wr_b_reg <= 1'b1;
         rd_b_reg <= 1'b1;
         start_reg <= 1'b0;
         pc_clear_reg <= 1'b0;
      end else begin
         // Boundary clock high in T1, and in TX outside data accesses
         instruction_boundary_clock_reg <= (state_next == ST_T1)
                     || (state_next == ST_TX && cls_next != CLS_DATA);
         // Latch strobe registered with the state: high across the data T1
         ale_reg <= (state_next == ST_T1) && (cls_next == CLS_DATA);
         // Write strobe low from the first TW through T2
         wr_b_reg <= !((cls_next == CLS_DATA) && !rd_next
                     && (state_next == ST_TW || state_next == ST_T2));
         // Read strobe low in the same window, plus the second TX of a four-state read
         rd_b_reg <= !((cls_next == CLS_DATA) && rd_next
                     && (state_next == ST_TW || state_next == ST_T2
                         || (state_next == ST_TX && !first_tx_next)));
         start_reg <= at_boundary && cpu_run_bit && (state_next == ST_T1) && !second_word_next;
         pc_clear_reg <= kick_start;
      end
   end

   // Outputs
   assign o_reg_rdata = rdata_reg;
   assign o_instruction_boundary_clock = instruction_boundary_clock_reg;
   assign o_addr_latch = ale_reg;
   assign o_write_strobe_b = wr_b_reg;
   assign o_read_strobe_b = rd_b_reg;
   assign o_bus_req = (state_reg == ST_T1) && is_data;
   assign o_instr_start = start_reg;
   assign o_pc_clear = pc_clear_reg;
   assign o_cpu_halted = (state_reg == ST_IDLE);

endmodule

// File: sim/ctw_timing_ctrl_properties.sv
// Concurrent checks on the ports of the timing controller
`timescale 1ns/1ps
module ctw_props
   import ctw_pkg::*;
(
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic [ADDR_W-1:0] i_reg_addr,
   input wire logic [DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [DATA_W-1:0] o_reg_rdata,
   input wire logic i_remote_busy,
   input wire logic o_instruction_boundary_clock,
   input wire logic o_addr_latch,
   input wire logic o_write_strobe_b,
   input wire logic o_read_strobe_b,
   input wire logic o_bus_req,
   input wire logic o_instr_start,
   input wire logic o_pc_clear,
   input wire logic o_cpu_halted
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   // Run bit written high at this edge
   wire run_wr = i_reg_wr && (i_reg_addr == REM_CFG_ADDR) && i_reg_wdata[RUN_BIT];

   chk_halt_quiet:
   assert property (o_cpu_halted |-> !o_instruction_boundary_clock && !o_bus_req
      && o_write_strobe_b && o_read_strobe_b && !o_instr_start)
      else $error("activity while halted");
   // Leaving idle needs a run write or a kick-start after reset
   chk_start_cause:
   assert property ($fell(o_cpu_halted) |-> $past(run_wr, 2) || $past(!i_rst_b, 2))
      else $error("left idle without a start");
   chk_bus_ale:
   assert property (o_bus_req |-> o_addr_latch && o_instruction_boundary_clock)
      else $error("bus request outside data T1");
   chk_busy_hold:
   assert property (o_bus_req && i_remote_busy |=> o_bus_req)
      else $error("T1 left during remote access");
   chk_tx_after:
   assert property ($fell(o_bus_req) |-> !o_addr_latch && !o_instruction_boundary_clock
      && o_write_strobe_b && o_read_strobe_b)
      else $error("bad TX after data T1");
   chk_write_late:
   assert property ($fell(o_write_strobe_b) |-> $past(!o_bus_req) && !o_instruction_boundary_clock)
      else $error("write strobe fell too early");
   // Strobe ends only into the next T1 or into idle
   chk_strobe_end:
   assert property ($rose(o_write_strobe_b) |-> o_instruction_boundary_clock || o_cpu_halted)
      else $error("write strobe ended mid instruction");
   chk_start_instruction_boundary_clock:
   assert property (o_instr_start |-> o_instruction_boundary_clock ##1 !o_instr_start)
      else $error("start pulse without boundary clock");
   // Dummy fetch: T1, three waits, T2, then the first real instruction
   chk_kick_seq:
   assert property (o_pc_clear |-> !o_cpu_halted && $past(o_cpu_halted)
      ##1 o_instruction_boundary_clock ##1 !o_instruction_boundary_clock [*4] ##1 o_instr_start)
      else $error("kick-start sequence wrong");
   // Read strobe only falls after the data T1 has ended
   chk_read_late:
   assert property ($fell(o_read_strobe_b) |-> !o_bus_req && !o_instruction_boundary_clock
      && o_write_strobe_b)
      else $error("read strobe fell too early");
   chk_rdata_idle:
   assert property (!$past(i_reg_rd) |-> o_reg_rdata == '0)
      else $error("read data outside its cycle");
endmodule

// File: sim/ctw_far_model.sv
// Far-side model: program memory giving instruction classes, host holding bus and wait
`timescale 1ns/1ps
module ctw_far_model (
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_instr_start,
   input wire logic [2:0] i_cls,
   input wire logic i_rd,
   input wire logic [1:0] i_hold,
   input wire logic [3:0] i_stall,
   output logic [2:0] o_instr_class,
   output logic o_data_read,
   output logic o_wait_b,
   output logic o_remote_busy
);
   logic [1:0] busy_reg; // Remaining host access cycles
   logic [3:0] stall_reg; // Remaining wait-low cycles
   // Memory presents the commanded class
   assign o_instr_class = i_cls;
   assign o_data_read = i_rd;
   // Host access starts with the instruction so the T1 decision sees it
   assign o_remote_busy = (i_instr_start && (i_hold != 2'h0)) || (busy_reg != 2'h0);
   // Wait pulled low early, released after a bounded time so the access ends
   assign o_wait_b = !((i_instr_start && (i_stall != 4'h0)) || (stall_reg != 4'h0));
   // Counters reload at each instruction start
   always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         busy_reg <= 2'h0;
         stall_reg <= 4'h0;
      end else if (i_instr_start) begin
         busy_reg <= (i_hold == 2'h0) ? 2'h0 : i_hold - 2'h1;
         stall_reg <= (i_stall == 4'h0) ? 4'h0 : i_stall - 4'h1;
      end else begin
         busy_reg <= (busy_reg == 2'h0) ? 2'h0 : busy_reg - 2'h1;
         stall_reg <= (stall_reg == 4'h0) ? 4'h0 : stall_reg - 4'h1;
      end
   end
endmodule

// File: sim/tb.sv
// Self-checking bench for the CPU timing and wait-state controller
`timescale 1ns/1ps
module tb;
   import ctw_pkg::*;
   logic i_mclk, i_rst_b, i_reg_wr, i_reg_rd, i_lock_b, rd, i_data_read, i_wait_b;
   logic [ADDR_W-1:0] i_reg_addr;
   logic [DATA_W-1:0] i_reg_wdata, o_reg_rdata, v;
   logic [2:0] cls, i_instr_class;
   logic [1:0] hold;
   logic [3:0] stall;
   logic i_remote_busy, i_remote_write_strobe_b, i_remote_read_strobe_b, i_remote_access_enable;
   logic o_instruction_boundary_clock, o_addr_latch, o_write_strobe_b, o_read_strobe_b;
   logic o_bus_req, o_instr_start, o_pc_clear, o_cpu_halted;
   int miscompares = 0;
   int compares = 0;
   int n, k;
   integer seed = 32'h42a9d2eb; // Fixed seed keeps runs repeatable
   // Corner rows: class, read, iw, dw, four-state, host hold
   int tc[9][6] = '{'{2, 0, 0, 0, 0, 0}, '{2, 1, 3, 0, 0, 0}, '{2, 1, 0, 1, 1, 0},
      '{2, 1, 0, 2, 1, 0}, '{2, 0, 2, 7, 1, 3}, '{4, 0, 3, 0, 0, 0}, '{3, 0, 1, 5, 0, 0},
      '{1, 0, 2, 0, 0, 2}, '{0, 0, 0, 0, 0, 0}};

   ctw_timing_ctrl u_dut (.i_mclk, .i_rst_b, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd,
      .o_reg_rdata, .i_instr_class, .i_data_read, .i_wait_b, .i_lock_b, .i_remote_busy,
      .i_remote_write_strobe_b, .i_remote_read_strobe_b, .i_remote_access_enable,
      .o_instruction_boundary_clock, .o_addr_latch, .o_write_strobe_b, .o_read_strobe_b,
      .o_bus_req, .o_instr_start, .o_pc_clear, .o_cpu_halted);
   ctw_far_model u_far (.i_mclk, .i_rst_b, .i_instr_start(o_instr_start), .i_cls(cls),
      .i_rd(rd), .i_hold(hold), .i_stall(stall), .o_instr_class(i_instr_class),
      .o_data_read(i_data_read), .o_wait_b(i_wait_b), .o_remote_busy(i_remote_busy));

   // 200 MHz clock
   initial begin
      i_mclk = 1'b0;
      forever #2.5 i_mclk = ~i_mclk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_mclk);
      i_reg_wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rreg(input logic [1:0] a, output logic [7:0] d);
      @(posedge i_mclk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_mclk);
      i_reg_rd <= 1'b0;
      @(negedge i_mclk);
      d = o_reg_rdata;
   endtask

   // Cycles up to the next start pulse, bounded
   task automatic gap(output int c);
      c = 0;
      do begin
         @(negedge i_mclk);
         c++;
      end while (o_instr_start !== 1'b1 && c < 200);
   endtask

   // Instruction length in T-states, host hold counted on data T1 only
   function automatic int exp_len(int c, int r, int iw, int dw, int f4, int b);
      int m;
      m = (dw > iw - 1) ? dw : iw - 1;
      if (f4 && r) begin
         m = (dw - 1 > iw - 2) ? dw - 1 : iw - 2;
         m = (m < 0) ? 0 : m;
      end
      case (c)
         0: return 2 + iw;
         1: return 3 + iw;
         3: return 4 + iw;
         4: return 4 + 2 * iw;
         default: return 3 + (f4 && r) + m + b;
      endcase
   endfunction

   // Program waits and far side, let changes settle, measure one instruction
   task automatic run_case(input int c, r, i, d, f, b, s);
      int e;
      e = exp_len(c, r, i, d, f, b);
      wreg(DEV_CTRL_ADDR, {3'h0, i[1:0], d[2:0]});
      wreg(AUX_CTRL_ADDR, {7'h0, f[0]});
      cls <= c[2:0];
      rd <= r[0];
      hold <= b[1:0];
      stall <= s[3:0];
      repeat (3) gap(n);
      gap(n);
      if (s == 0) begin
         chk(8'(n), 8'(e));
      end else begin
         chk(8'(n >= s + 2 && n <= s + e + 8), 8'h01);
      end
   endtask

   task automatic conclude();
      if (miscompares == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Hang guard, far beyond the expected run
   initial begin
      #200000;
      miscompares++;
      conclude();
   end

   initial begin
      i_rst_b = 1'b0;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      i_reg_addr = '0;
      i_reg_wdata = '0;
      i_lock_b = 1'b1;
      cls = 3'h0;
      rd = 1'b0;
      hold = 2'h0;
      stall = 4'h0;
      i_remote_write_strobe_b = 1'b1; // No kick-start on the first reset
      i_remote_read_strobe_b = 1'b1;
      i_remote_access_enable = 1'b0;
      repeat (20) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      rreg(DEV_CTRL_ADDR, v);
      chk(v, 8'h1f);
      rreg(AUX_CTRL_ADDR, v);
      chk(v, 8'h00);
      wreg(STATUS_ADDR, 8'hff);
      rreg(STATUS_ADDR, v);
      chk(v, 8'h01);
      wreg(REM_CFG_ADDR, 8'h01);
      gap(n);
      chk(8'(n), 8'h08);
      for (k = 0; k < 9; k++) begin
         run_case(tc[k][0], tc[k][1], tc[k][2], tc[k][3], tc[k][4], tc[k][5], 0);
      end
      for (k = 0; k < 14; k++) begin
         run_case($unsigned($random(seed)) % 5, $unsigned($random(seed)) % 2,
            $unsigned($random(seed)) % 4, $unsigned($random(seed)) % 8,
            $unsigned($random(seed)) % 2, $unsigned($random(seed)) % 4, 0);
      end
      run_case(2, 0, 0, 7, 0, 0, 12);
      run_case(2, 1, 0, 7, 0, 0, 12);
      // Locked bus keeps a data T1 waiting
      @(posedge i_mclk);
      i_lock_b <= 1'b0;
      stall <= 4'h0;
      repeat (8) @(posedge i_mclk);
      k = 0;
      while (o_bus_req !== 1'b1 && k < 100) begin
         @(negedge i_mclk);
         k++;
      end
      repeat (10) @(negedge i_mclk);
      chk(8'(o_bus_req), 8'h01);
      @(posedge i_mclk);
      i_lock_b <= 1'b1;
      repeat (10) @(negedge i_mclk);
      chk(8'(o_bus_req), 8'h00);
      // Stop, stay idle, restart with one instruction wait
      wreg(REM_CFG_ADDR, 8'h00);
      k = 0;
      while (o_cpu_halted !== 1'b1 && k < 100) begin
         @(negedge i_mclk);
         k++;
      end
      repeat (10) @(negedge i_mclk);
      chk(8'({o_instr_start, o_cpu_halted}), 8'h01);
      wreg(DEV_CTRL_ADDR, 8'h0a);
      wreg(REM_CFG_ADDR, 8'h01);
      gap(n);
      chk(8'(n), 8'h06);
      // Second reset with the kick-start straps set
      @(posedge i_mclk);
      i_rst_b <= 1'b0;
      i_remote_write_strobe_b <= 1'b0;
      i_remote_read_strobe_b <= 1'b0;
      i_remote_access_enable <= 1'b1;
      repeat (4) @(posedge i_mclk);
      i_rst_b <= 1'b1;
      gap(n);
      chk(8'(n), 8'h08);
      @(posedge i_mclk);
      i_remote_write_strobe_b <= 1'b1;
      rreg(DEV_CTRL_ADDR, v);
      chk(v, 8'h1f);
      conclude();
   end
endmodule

bind ctw_timing_ctrl ctw_props u_props (.i_mclk, .i_rst_b, .i_reg_addr, .i_reg_wdata,
   .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_remote_busy, .o_instruction_boundary_clock,
   .o_addr_latch, .o_write_strobe_b, .o_read_strobe_b, .o_bus_req, .o_instr_start,
   .o_pc_clear, .o_cpu_halted);
